//--- hdl/dps_entry_table.sv
// opcode-indexed entry table with registered readout
`timescale 1ns/1ps
module dps_entry_table
    import dps_pkg::*;
#(
    parameter int AW = OPC_W,
    parameter int DW = UA_W
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [(1<<AW)-1:0] present_q;

    // absent word lines read as zeros
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            present_q <= '0;
        end else if (wr_en) begin
            present_q[wr_addr] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= present_q[rd_addr] ? mem[rd_addr] : '0;
        end
    end
endmodule : dps_entry_table

//--- hdl/dps_phase_ptr.sv
// two-bit phase pointer with restricted transitions
`timescale 1ns/1ps
module dps_phase_ptr
    import dps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic init,
    input wire logic step,
    input wire logic [1:0] target,
    output logic [1:0] phase_q
);
    logic legal;

    // only the documented moves are accepted
    assign legal = (phase_q == PH_ZERO && (target == PH_ONE || target == PH_TWO))
                || (phase_q == PH_ONE && target == PH_TWO)
                || (phase_q == PH_TWO && (target == PH_ZERO || target == PH_THREE))
                || (phase_q == PH_THREE && target == PH_ZERO)
                || target == PH_THREE;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= PH_THREE;
        end else if (init) begin
            phase_q <= PH_THREE;
        end else if (step && legal) begin
            phase_q <= target;
        end
    end
endmodule : dps_phase_ptr

//--- hdl/dps_sequencer.sv
// decode micro-instruction sequencer with phase control
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - zero opcode is decode, two halves
// - bit 12 starts memory read, first half
// - bit 13 copies flags to condition code
// - bit 14 clears flags, counter, flops
// - bit 15 changes phase and microaddress
// - clear microaddress then load entry
// - phase two entry from table
// - table indexed by opcode, first half
// - clear only illegal or phase change
// - three ways into phase two
// - phase zero regreg routes divide work to address
// - phase zero regreg passes B to S
// - no destination writes in second half, except phase zero regreg
// - phase zero regreg skips step and strobe
// - non regreg forces program counter routing
// - add zero, optionally add two
// - decode and illegal take two clocks
// - phase pointer moves, initialize gives three
// - phase zero and one entry addresses
// - interrupt and illegal phase three entries
module dps_sequencer
    import dps_pkg::*;
#(
    parameter bit ADD_TWO_EN = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic init,
    input wire logic mw_valid,
    input wire logic [MW_W-1:0] microword,
    input wire logic [OPC_W-1:0] user_opcode_holder,
    input wire logic is_regreg,
    input wire logic is_rs_unindexed,
    input wire logic is_rx,
    input wire logic r1_nonzero,
    input wire logic irq_pending,
    input wire logic table_wr,
    input wire logic [OPC_W-1:0] table_wr_addr,
    input wire logic [UA_W-1:0] table_wr_data,
    output logic busy,
    output logic first_half_flag,
    output logic memory_read_start,
    output logic condition_copy_pulse,
    output logic decode_clear_pulse,
    output logic phase_change_request,
    output logic microaddress_clear,
    output logic microaddr_load,
    output logic [UA_W-1:0] microaddr_q,
    output logic [1:0] phase,
    output logic phase_zero_regreg,
    output logic destination_kill,
    output logic microaddress_step_clock,
    output logic microstore_strobe,
    output logic skip_override,
    output logic force_pc_routing,
    output logic logic_fn_suppress,
    output logic [1:0] src_sel,
    output logic [1:0] dst_sel,
    output logic [15:0] adder_input,
    output logic adder_input_line_two,
    output logic illegal_microword
);
    dps_state_t state_q, state_d;
    logic [MW_W-1:0] mw_q;
    logic [1:0] target_q;
    logic from_table_q;
    logic [UA_W-1:0] fixed_q;
    logic [UA_W-1:0] table_rd;
    logic is_zero_op, is_decode, is_illegal, go_phase_two, entry_table_enable;
    logic [1:0] target_d;
    logic [UA_W-1:0] fixed_d;
    logic in_first, in_second, p0_regreg_w, chg;

    // extended bit pick, bit 0 is the msb as printed
    function automatic logic xbit(input logic [MW_W-1:0] w, input int pos);
        xbit = w[pos];
    endfunction : xbit

    assign is_zero_op = mw_valid && microword[OP_HI:OP_LO] == DECODE_OP;
    assign is_decode = is_zero_op && xbit(microword, SRC_BIT9);
    assign is_illegal = is_zero_op && !xbit(microword, SRC_BIT9) && !init;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mw_q <= '0;
        end else if (state_q == DPS_IDLE && is_zero_op) begin
            mw_q <= microword;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            DPS_IDLE: begin
                if (is_zero_op && !init) begin
                    state_d = DPS_FIRST;
                end
            end
            DPS_FIRST: begin
                state_d = DPS_SECOND;
            end
            DPS_SECOND: begin
                state_d = DPS_IDLE;
            end
            default: begin
                state_d = DPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= DPS_IDLE;
        end else if (init) begin
            state_q <= DPS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign in_first = state_q == DPS_FIRST;
    assign in_second = state_q == DPS_SECOND;
    assign busy = state_q != DPS_IDLE;
    assign first_half_flag = in_first;
    assign illegal_microword = busy && !xbit(mw_q, SRC_BIT9);
    assign chg = busy && xbit(mw_q, SRC_BIT9) && xbit(mw_q, XB15);

    assign go_phase_two = (phase == PH_ONE) || (phase == PH_ZERO && is_regreg)
                       || (phase == PH_ZERO && is_rs_unindexed);
    assign p0_regreg_w = phase == PH_ZERO && is_regreg && busy && !illegal_microword;

    always_comb begin
        target_d = PH_ZERO;
        fixed_d = ENTRY_P0;
        if (is_illegal) begin
            target_d = PH_THREE;
            fixed_d = ENTRY_ILLEGAL;
        end else if (go_phase_two) begin
            target_d = PH_TWO;
            fixed_d = UA_RESET;
        end else if (phase == PH_ZERO) begin
            target_d = PH_ONE;
            fixed_d = (is_rx && r1_nonzero) ? ENTRY_P1_IDX : ENTRY_P1;
        end else if (phase == PH_TWO && irq_pending) begin
            target_d = PH_THREE;
            fixed_d = ENTRY_IRQ;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            target_q <= PH_THREE;
            fixed_q <= UA_RESET;
            from_table_q <= 1'b0;
        end else if (state_q == DPS_IDLE && is_zero_op) begin
            target_q <= target_d;
            fixed_q <= fixed_d;
            from_table_q <= target_d == PH_TWO;
        end
    end

    // table read enabled on phase two entry
    assign entry_table_enable = state_q == DPS_IDLE && is_decode
                             && xbit(microword, XB15) && go_phase_two;

    dps_entry_table #(
        .AW(OPC_W),
        .DW(UA_W)
    ) u_table (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(table_wr),
        .wr_addr(table_wr_addr),
        .wr_data(table_wr_data),
        .rd_en(entry_table_enable),
        .rd_addr(user_opcode_holder),
        .rd_data(table_rd)
    );

    dps_phase_ptr u_phase (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .init(init),
        .step(in_second && (chg || illegal_microword)),
        .target(target_q),
        .phase_q(phase)
    );

    assign memory_read_start = in_first && !illegal_microword && xbit(mw_q, XB12)
                            && !(phase == PH_ZERO && is_regreg);
    assign condition_copy_pulse = in_first && !illegal_microword && xbit(mw_q, XB13);
    assign decode_clear_pulse = in_second && !illegal_microword && xbit(mw_q, XB14);
    assign phase_change_request = chg;
    // clear in first half, load in second
    assign microaddress_clear = in_first && (illegal_microword || chg);
    assign microaddr_load = in_second && (illegal_microword || chg);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            microaddr_q <= UA_RESET;
        end else if (init || microaddress_clear) begin
            microaddr_q <= UA_RESET;
        end else if (microaddr_load) begin
            microaddr_q <= from_table_q ? table_rd : fixed_q;
        end
    end

    assign phase_zero_regreg = p0_regreg_w;
    assign logic_fn_suppress = p0_regreg_w;
    assign skip_override = p0_regreg_w;
    assign microaddress_step_clock = !(in_second && p0_regreg_w) && !busy;
    assign microstore_strobe = !(in_second && p0_regreg_w) && !busy;
    assign destination_kill = in_second && !p0_regreg_w;
    assign force_pc_routing = busy && !(phase == PH_ZERO && is_regreg);
    assign src_sel = p0_regreg_w ? DPS_REG_DIVWORK : DPS_REG_PC;
    assign dst_sel = p0_regreg_w ? DPS_REG_OPADDR : DPS_REG_PC;
    assign adder_input_line_two = ADD_TWO_EN && force_pc_routing;
    assign adder_input = adder_input_line_two ? ADD_TWO : ADD_ZERO;
endmodule : dps_sequencer

//--- inc/dps_pkg.sv
// constants and types for the decode micro-op phase sequencer
package dps_pkg;
    localparam int UA_W = 12;
    localparam int MW_W = 16;
    localparam int OPC_W = 8;
    // microword field positions, bit 0 at the msb side as printed
    localparam int OP_HI = 15;
    localparam int OP_LO = 12;
    localparam int XB12 = 3;
    localparam int XB13 = 2;
    localparam int XB14 = 1;
    localparam int XB15 = 0;
    localparam int SRC_BIT9 = 6;
    // fixed entry addresses
    localparam logic [11:0] ENTRY_P0 = 12'h010;
    localparam logic [11:0] ENTRY_P1_IDX = 12'h00c;
    localparam logic [11:0] ENTRY_P1 = 12'h008;
    localparam logic [11:0] ENTRY_IRQ = 12'h014;
    localparam logic [11:0] ENTRY_ILLEGAL = 12'h200;
    localparam logic [11:0] UA_RESET = 12'h000;
    localparam logic [3:0] DECODE_OP = 4'h0;
    localparam logic [15:0] ADD_TWO = 16'h0002;
    localparam logic [15:0] ADD_ZERO = 16'h0000;
    // phase pointer values
    localparam logic [1:0] PH_ZERO = 2'h0;
    localparam logic [1:0] PH_ONE = 2'h1;
    localparam logic [1:0] PH_TWO = 2'h2;
    localparam logic [1:0] PH_THREE = 2'h3;
    // register routing codes
    typedef enum logic [1:0] {
        DPS_REG_PC,
        DPS_REG_DIVWORK,
        DPS_REG_OPADDR
    } dps_reg_t;
    typedef enum logic [1:0] {
        DPS_IDLE,
        DPS_FIRST,
        DPS_SECOND
    } dps_state_t;
endpackage : dps_pkg

//--- sim/dps_sequencer_sva.sv
// port checker for the decode phase sequencer
`timescale 1ns/1ps
module dps_sequencer_sva
    import dps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic init,
    input wire logic mw_valid,
    input wire logic [MW_W-1:0] microword,
    input wire logic is_regreg,
    input wire logic busy,
    input wire logic first_half_flag,
    input wire logic memory_read_start,
    input wire logic condition_copy_pulse,
    input wire logic decode_clear_pulse,
    input wire logic microaddress_clear,
    input wire logic [UA_W-1:0] microaddr_q,
    input wire logic [1:0] phase,
    input wire logic phase_zero_regreg,
    input wire logic destination_kill,
    input wire logic microaddress_step_clock,
    input wire logic microstore_strobe,
    input wire logic phase_change_request,
    input wire logic microaddr_load,
    input wire logic skip_override,
    input wire logic force_pc_routing,
    input wire logic logic_fn_suppress,
    input wire logic [1:0] src_sel,
    input wire logic [1:0] dst_sel,
    input wire logic [15:0] adder_input,
    input wire logic adder_input_line_two,
    input wire logic illegal_microword
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    wire take = !busy && !init && mw_valid && microword[OP_HI:OP_LO] == DECODE_OP;
    wire dec = take && microword[SRC_BIT9];
    property p_two; take |=> first_half_flag ##1 (busy && !first_half_flag); endproperty
    a_two: assert property (p_two) else $error("decode length wrong");
    property p_rd; dec |=> memory_read_start == ($past(microword[XB12])
        && !($past(phase) == PH_ZERO && $past(is_regreg))); endproperty
    a_rd: assert property (p_rd) else $error("read start wrong");
    property p_cc; dec && microword[XB13] |=> condition_copy_pulse ##1 !condition_copy_pulse;
    endproperty
    a_cc: assert property (p_cc) else $error("copy pulse wrong");
    property p_clr; dec |=> !decode_clear_pulse ##1 decode_clear_pulse == $past(microword[XB14], 2);
    endproperty
    a_clr: assert property (p_clr) else $error("clear pulse wrong");
    property p_uac; microaddress_clear |-> first_half_flag && busy; endproperty
    a_uac: assert property (p_uac) else $error("address clear outside first half");
    property p_kill; busy && !first_half_flag && !phase_zero_regreg |-> destination_kill;
    endproperty
    a_kill: assert property (p_kill) else $error("destination not killed");
    property p_step; busy |-> !microaddress_step_clock && !microstore_strobe; endproperty
    a_step: assert property (p_step) else $error("step clock during decode");
    property p_p0; dec && microword[XB15] && phase == PH_THREE
        |=> ##2 (phase == PH_ZERO && microaddr_q == ENTRY_P0); endproperty
    a_p0: assert property (p_p0) else $error("phase zero entry wrong");
    property p_ill; first_half_flag |-> illegal_microword == !$past(microword[SRC_BIT9])
        && phase_change_request == ($past(microword[SRC_BIT9]) && $past(microword[XB15]));
    endproperty
    a_ill: assert property (p_ill) else $error("illegal or change flag wrong");
    property p_load; busy
        |-> microaddr_load == (!first_half_flag && (phase_change_request || illegal_microword))
        && microaddress_clear == (first_half_flag && (phase_change_request || illegal_microword));
    endproperty
    a_load: assert property (p_load) else $error("address clear or load wrong");
    property p_rr; busy && phase == PH_ZERO && is_regreg && !illegal_microword
        |-> phase_zero_regreg && logic_fn_suppress && skip_override && !force_pc_routing
        && src_sel == DPS_REG_DIVWORK && dst_sel == DPS_REG_OPADDR; endproperty
    a_rr: assert property (p_rr) else $error("regreg routing wrong");
    property p_pc; busy && !(phase == PH_ZERO && is_regreg)
        |-> force_pc_routing && !phase_zero_regreg && src_sel == DPS_REG_PC
        && dst_sel == DPS_REG_PC && adder_input == {14'h0000, adder_input_line_two, 1'b0};
    endproperty
    a_pc: assert property (p_pc) else $error("pc routing wrong");
endmodule : dps_sequencer_sva

//--- sim/dps_sequencer_tb.sv
// self-checking bench for the decode phase sequencer
`timescale 1ns/1ps
module dps_sequencer_tb
    import dps_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic init = 1'b0;
    logic put = 1'b0;
    logic twr = 1'b0;
    logic rr = 1'b0, rs_u = 1'b0, rx = 1'b0, r1 = 1'b0, irq = 1'b0;
    logic [7:0] opc = 8'h00, twa = 8'h00;
    logic [11:0] twd = 12'h000;
    logic [15:0] word = 16'h0000;
    logic [15:0] mw;
    logic mwv, busy, fh, rs, cc, cl;
    logic [11:0] ua;
    logic [1:0] ph;
    logic [11:0] tbl [0:255] = '{default: 12'h000};
    logic [31:0] seed = 32'h487d0eba;
    int error_cnt = 0;
    int num_checks = 0;
    dps_ustore_model u_far (.sys_clk(sys_clk), .rst_b(rst_b), .busy(busy), .put(put),
        .word(word), .mw_valid(mwv), .microword(mw));
    dps_sequencer dut (.sys_clk(sys_clk), .rst_b(rst_b), .init(init), .mw_valid(mwv),
        .microword(mw), .user_opcode_holder(opc), .is_regreg(rr), .is_rs_unindexed(rs_u),
        .is_rx(rx), .r1_nonzero(r1), .irq_pending(irq), .table_wr(twr),
        .table_wr_addr(twa), .table_wr_data(twd), .busy(busy), .first_half_flag(fh),
        .memory_read_start(rs), .condition_copy_pulse(cc), .decode_clear_pulse(cl),
        .phase_change_request(), .microaddress_clear(), .microaddr_load(),
        .microaddr_q(ua), .phase(ph), .phase_zero_regreg(), .destination_kill(),
        .microaddress_step_clock(), .microstore_strobe(), .skip_override(),
        .force_pc_routing(), .logic_fn_suppress(), .src_sel(), .dst_sel(),
        .adder_input(), .adder_input_line_two(), .illegal_microword());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [13:0] nxt(input logic [1:0] p, input logic [15:0] w);
        if (!w[SRC_BIT9]) return {PH_THREE, ENTRY_ILLEGAL};
        if (!w[XB15]) return {p, ua};
        case (p)
            PH_ZERO: if (rr || rs_u) return {PH_TWO, tbl[opc]};
                else return {PH_ONE, r1 ? ENTRY_P1_IDX : ENTRY_P1};
            PH_ONE: return {PH_TWO, tbl[opc]};
            PH_TWO: return irq ? {PH_THREE, ENTRY_IRQ} : {PH_ZERO, ENTRY_P0};
            default: return {PH_ZERO, ENTRY_P0};
        endcase
    endfunction : nxt
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic run_dec(input logic [15:0] w);
        logic [13:0] e;
        logic [2:0] g, x;
        logic seen;
        g = 3'b000;
        seen = 1'b0;
        repeat (seed[9:8]) @(posedge sys_clk);
        @(posedge sys_clk);
        e = nxt(ph, w);
        x = {w[XB12] && !(ph == PH_ZERO && rr), w[XB13], w[XB14]};
        put <= 1'b1;
        word <= w;
        @(posedge sys_clk);
        put <= 1'b0;
        for (int n = 0; n < 12 && !(seen && busy === 1'b0); n++) begin
            @(negedge sys_clk);
            if (fh === 1'b1) g[2:1] = {rs, cc};
            if (busy === 1'b1 && fh === 1'b0) g[0] = cl;
            seen = seen | (busy === 1'b1);
        end
        check({11'h000, g}, {11'h000, x});
        check({ph, ua}, e);
    endtask : run_dec
    initial forever #20 sys_clk = ~sys_clk;
    initial begin
        repeat (4000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        check({ph, ua}, {PH_THREE, UA_RESET});
        for (int i = 1; i < 5; i++) begin
            tbl[i] = 12'h100 + 12'(i * 37);
            @(posedge sys_clk);
            twr <= 1'b1;
            twa <= 8'(i);
            twd <= tbl[i];
        end
        @(posedge sys_clk);
        twr <= 1'b0;
        run_dec(16'h004f);
        run_dec(16'h0000);
        $display("test corners done");
        for (int k = 0; k < 60; k++) begin
            seed = lfsr(seed);
            @(posedge sys_clk);
            rr <= seed[0];
            rs_u <= !seed[0] && seed[1];
            rx <= !seed[0] && !seed[1];
            r1 <= seed[2];
            irq <= seed[3];
            opc <= {5'h00, seed[6:4]};
            run_dec(seed[17:15] == 3'h0 ? 16'h0000 : {12'h004, seed[13:11], seed[10] | seed[14]});
        end
        $display("test random done");
        @(posedge sys_clk);
        init <= 1'b1;
        @(posedge sys_clk);
        init <= 1'b0;
        @(negedge sys_clk);
        check({ph, ua}, {PH_THREE, UA_RESET});
        $display("test init done");
        tally_and_finish();
    end
endmodule : dps_sequencer_tb
bind dps_sequencer dps_sequencer_sva u_sva (.sys_clk(sys_clk), .rst_b(rst_b), .init(init),
    .mw_valid(mw_valid), .microword(microword), .is_regreg(is_regreg), .busy(busy),
    .first_half_flag(first_half_flag), .memory_read_start(memory_read_start),
    .condition_copy_pulse(condition_copy_pulse), .decode_clear_pulse(decode_clear_pulse),
    .microaddress_clear(microaddress_clear), .microaddr_q(microaddr_q), .phase(phase),
    .phase_zero_regreg(phase_zero_regreg), .destination_kill(destination_kill),
    .microaddress_step_clock(microaddress_step_clock),
    .microstore_strobe(microstore_strobe), .phase_change_request(phase_change_request),
    .microaddr_load(microaddr_load), .skip_override(skip_override),
    .force_pc_routing(force_pc_routing), .logic_fn_suppress(logic_fn_suppress),
    .src_sel(src_sel), .dst_sel(dst_sel), .adder_input(adder_input),
    .adder_input_line_two(adder_input_line_two), .illegal_microword(illegal_microword));

//--- sim/dps_ustore_model.sv
// microstore side model presenting one microword per request
`timescale 1ns/1ps
module dps_ustore_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic busy,
    input wire logic put,
    input wire logic [15:0] word,
    output logic mw_valid,
    output logic [15:0] microword
);
    // once taken the word is dropped and the lines show its inverse
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mw_valid <= 1'b0;
            microword <= 16'hffff;
        end else if (put) begin
            mw_valid <= 1'b1;
            microword <= word;
        end else if (busy && mw_valid) begin
            mw_valid <= 1'b0;
            microword <= ~microword;
        end
    end
endmodule : dps_ustore_model
